/* File: bench/line_memory.sv */
// behavioural line memory with random grant and wait cycles
module line_memory (
	input wire logic clk_in,
	input wire cache_pkg::mem_cmd_t cmd_in,
	input wire logic [127:0] wdata_in,
	output logic grant_out,
	output cache_pkg::status_t status_out,
	output logic [127:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// byte j of a line at bits 8j, the placement the cache assumes in either order
	logic [127:0] mem [logic [31:0]];
	logic [31:0] rng = 32'h1357_9bdf;
	logic [1:0] cnt = 2'h0;
	initial begin
		grant_out = 1'b0;
		status_out = cache_pkg::wait_status;
		rdata_out = '0;
	end
	// random grant, waits, then one ok cycle
	always @(posedge clk_in) begin
		rng <= rng ^ (rng << 5) ^ (rng >> 3);
		grant_out <= cmd_in.req & rng[0];
		if (status_out != cache_pkg::wait_status) begin
			status_out <= cache_pkg::wait_status;
			rdata_out <= ~rdata_out;
			if (cmd_in.wr) mem[cmd_in.addr] = wdata_in;
		end else if ((cmd_in.rd | cmd_in.wr) && cnt == 2'h0) begin
			status_out <= cache_pkg::ok_status;
			if (cmd_in.rd) rdata_out <= mem.exists(cmd_in.addr) ? mem[cmd_in.addr] : '0;
		end else if (cmd_in.rd | cmd_in.wr) cnt <= cnt - 2'h1;
		else cnt <= rng[3:2];
	end
endmodule

/* File: bench/tb_cache_top.sv */
// random traffic, register and counter checks of the cache
module tb_cache_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, rst_in = 1, up_valid_in = 0, grant;
	cache_pkg::up_req_t up_req_in = '0;
	cache_pkg::status_t up_status_out, mstat;
	cache_pkg::mem_cmd_t mcmd;
	logic [63:0] up_rdata_out, mk, x;
	logic [127:0] mwdata, mrdata;
	logic [7:0] av_address_in = 8'h00;
	logic av_read_in = 0, av_write_in = 0, av_waitrequest_out;
	logic [31:0] av_writedata_in = '0, av_readdata_out, rng = 32'h0572_880a, rd, lim = '1, r;
	logic [31:0] cnt [6] = '{default: 0};
	logic [31:0] rsz = '0;
	logic [7:0] shadow [logic [31:0]];
	logic [65:0] expq [$];
	logic [63:0] mq [$];
	logic [3:0] ctrl = 4'h3;
	logic [3:0] phases [5] = '{4'h2, 4'h3, 4'h5, 4'h7, 4'hf};
	int fails = 0, num_checks = 0, cyc = 0;
	cache_top cache_top_inst (.clk_in(clk_in), .rst_in(rst_in), .up_valid_in(up_valid_in),
		.up_req_in(up_req_in), .up_status_out(up_status_out), .up_rdata_out(up_rdata_out),
		.mem_cmd_out(mcmd), .mem_wdata_out(mwdata), .mem_grant_in(grant), .mem_status_in(mstat),
		.mem_rdata_in(mrdata), .av_address_in(av_address_in), .av_read_in(av_read_in),
		.av_write_in(av_write_in), .av_writedata_in(av_writedata_in), .av_byteenable_in(4'hf),
		.av_readdata_out(av_readdata_out), .av_waitrequest_out(av_waitrequest_out));
	line_memory line_memory_inst (.clk_in(clk_in), .cmd_in(mcmd), .wdata_in(mwdata),
		.grant_out(grant), .status_out(mstat), .rdata_out(mrdata));
	initial forever #25 clk_in = ~clk_in;
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		fails += expq.size();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// one avalon cycle, held until waitrequest is seen low
	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		av_address_in <= a;
		av_writedata_in <= d;
		av_write_in <= w;
		av_read_in <= !w;
		// request stands until the rising edge that samples waitrequest low
		do @(posedge clk_in); while (av_waitrequest_out !== 1'b0);
		rd = av_readdata_out;
		av_write_in <= 1'b0;
		av_read_in <= 1'b0;
	endtask
	// one upstream access; notes the expected answer first
	task automatic up(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [63:0] d);
		logic [31:0] m;
		logic [63:0] e;
		int n, nb, j;
		m = a & lim;
		e = '0;
		mk = '0;
		if (s inside {[1:4]} && (rsz == '0 || m < rsz)) begin
			nb = 1 << (s - 1);
			for (int k = 0; k < nb; k++) begin
				j = ctrl[3] ? nb - 1 - k : k;
				if (w) shadow[m + k] = d[8*j +: 8];
				else e[8*j +: 8] = shadow.exists(m + k) ? shadow[m + k] : 8'h00;
				if (!w) mk[8*j +: 8] = 8'hff;
			end
			// counters move only with profiling on
			if (ctrl[1]) begin
				cnt[((!ctrl[0] || (m >= 32'h200 && m < 32'h300)) ? 2 : 0) + int'(w)]++;
				if ((m & (nb - 1)) != 0) cnt[4]++;
				if ((m >> 4) != ((m + nb - 1) >> 4)) cnt[5]++;
			end
			expq.push_back({cache_pkg::ok_status, e});
		end else expq.push_back({cache_pkg::error_status, 64'h0});
		mq.push_back(mk);
		@(posedge clk_in);
		up_valid_in <= 1'b1;
		up_req_in <= '{w, a, s, d};
		n = 0;
		do @(negedge clk_in); while (up_status_out === cache_pkg::wait_status && ++n < 300);
		@(posedge clk_in);
		up_valid_in <= 1'b0;
	endtask
	// compare each completion with the oldest noted answer
	always @(negedge clk_in) if (!rst_in && up_status_out !== cache_pkg::wait_status) begin
		x = (expq.size() > 0) ? expq[0][63:0] : '1;
		chk(up_status_out, (expq.size() > 0) ? expq[0][65:64] : 2'h3);
		chk(up_rdata_out & ((mq.size() > 0) ? mq[0] : '1), x);
		if (expq.size() > 0) expq.pop_front();
		if (mq.size() > 0) mq.pop_front();
	end
	// cut a hang short
	always @(posedge clk_in) if (++cyc > 20000) begin
		fails++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		av(0, cache_pkg::REG_CTRL, 0);
		chk(rd, 64'h3);
		av(0, 8'h30, 0);
		chk(rd, 64'h0);
		av(1, cache_pkg::REG_NC_FIRST, 32'h0000_0200);
		av(1, cache_pkg::REG_NC_FIRST + 8'h04, 32'h0000_0100);
		av(1, cache_pkg::REG_NC_FIRST + 8'h08, 32'h0000_0100);
		foreach (phases[p]) begin
			ctrl = phases[p];
			av(1, cache_pkg::REG_CTRL, {28'h0, ctrl});
			repeat (24) begin
				r = xs();
				up(r[0], r & 32'h0000_05f7, {1'b0, r[2:1]} + 3'h1, {xs(), xs()});
			end
			up(r[3], 32'h0000_0240 + r[7:4], 3'h3, {32'h0, xs()});
			up(0, 32'h0000_0240 + r[7:4], 3'h3, 64'h0);
			up(r[5], 32'h0000_011c + r[9:8], 3'h4, {xs(), xs()});
			up(0, 32'h0000_011c + r[9:8], 3'h4, 64'h0);
		end
		up(0, 32'h0000_0010, 3'h0, 64'h0);
		up(1, 32'h0000_0010, 3'h5, 64'h0);
		av(1, cache_pkg::REG_VALID_WIDTH, 32'h0000_000c);
		lim = 32'h0000_0fff;
		up(0, 32'habcd_e010, 3'h4, 64'h0);
		av(1, cache_pkg::REG_REGION_SIZE, 32'h0000_0100);
		rsz = 32'h0000_0100;
		up(0, 32'h0000_0180, 3'h1, 64'h0);
		up(1, 32'h0000_00f0, 3'h1, 64'h5a);
		for (int k = 0; k < 6; k++) begin
			av(0, cache_pkg::REG_COUNT_FIRST + 8'(4 * k), 0);
			chk(rd, cnt[k]);
		end
		test_done();
	end
endmodule

/* File: logic/cache_pkg.sv */
// shared constants, codes and carriers of the direct-mapped cache
package cache_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int MAX_ACCESS_BYTES = 8;
	localparam int NC_WINDOWS = 4;
	localparam int NUM_COUNTERS = 11;
	localparam int AV_ADDR_W = 8;
	localparam int LINE_BYTES_MIN = 8;
	localparam int LINE_BYTES_MAX = 64;
	// register byte offsets on the avalon slave
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_REGION_BASE = 8'h04;
	localparam logic [7:0] REG_REGION_SIZE = 8'h08;
	localparam logic [7:0] REG_VALID_WIDTH = 8'h0C;
	localparam logic [7:0] REG_NC_FIRST = 8'h10; // window base at +0, size at +4
	localparam logic [7:0] REG_NC_LAST = 8'h2C;
	localparam logic [7:0] REG_COUNT_FIRST = 8'h40;
	localparam logic [7:0] REG_COUNT_LAST = 8'h68;
	localparam int NC_STRIDE_SHIFT = 3;
	localparam int NC_SIZE_BIT = 2;
	localparam int WORD_SHIFT = 2;
	// reset values
	localparam logic [3:0] CFG_RESET = 4'h3;
	localparam logic [31:0] REGION_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] REGION_SIZE_RESET = 32'h0000_0000; // zero covers all space
	localparam logic [5:0] VALID_WIDTH_RESET = 6'h20;
	localparam logic [5:0] VALID_WIDTH_FULL = 6'h20;
	localparam logic [31:0] NC_RESET = 32'h0000_0000;
	// upstream size codes
	localparam logic [2:0] SIZE_BYTE = 3'h1;
	localparam logic [2:0] SIZE_HALF = 3'h2;
	localparam logic [2:0] SIZE_WORD = 3'h3;
	localparam logic [2:0] SIZE_DWORD = 3'h4;
	// profiling counter indices
	localparam int CNT_RD_CACHED = 0;
	localparam int CNT_WR_CACHED = 1;
	localparam int CNT_RD_UNCACHED = 2;
	localparam int CNT_WR_UNCACHED = 3;
	localparam int CNT_MISALIGNED = 4;
	localparam int CNT_CROSS_LINE = 5;
	localparam int CNT_RD_WAITS = 6;
	localparam int CNT_WR_WAITS = 7;
	localparam int CNT_HITS = 8;
	localparam int CNT_RD_MISSES = 9;
	localparam int CNT_DIRTY_WRITES = 10;
	typedef enum logic [1:0] {wait_status, ok_status, error_status} status_t;
	typedef struct packed {
		logic write;
		logic [31:0] addr;
		logic [2:0] size;
		logic [63:0] wdata;
	} up_req_t;
	typedef struct packed {
		logic req;
		logic rd;
		logic wr;
		logic [31:0] addr;
	} mem_cmd_t;
	typedef struct packed {
		logic big_endian;
		logic copyback_policy;
		logic profiling_on;
		logic caching_on;
	} cfg_t;
endpackage

/* File: logic/cache_top.sv */
// direct-mapped cache with whole-line memory port, profiling counters and avalon registers
// Function
// - line size is a power of two from 8 to 64 bytes
// - capacity is a power of two multiple of line size, rounded upward
// - every downstream transfer moves one complete line
// - write-through narrow write fetches, merges, writes whole line, line stays resident
// - a flag picks write-back when set, write-through when clear
// - four non-cacheable windows by base and byte size bypass the cache
// - a window of size zero is disabled
// - misaligned and two-line accesses accepted; both lines share cacheability
// - with caching off every access goes uncached to memory
// - requests carry 32-bit address, up to 64-bit data, size codes 1 to 4
// - requester repeats while wait; each request ends ok or error
// - on an arbitrated bus, request and get grant before any transfer
// - a flag picks big-endian byte placement when set, little-endian when clear
// - address bits above the valid width are forced to zero
// - only the configured base and size region is served
// - counters run only with profiling on; cached reads and writes counted apart
// - uncached reads and writes counted apart; all accesses when caching off
// - misaligned accesses and two-line accesses each have a counter
// - memory read and write wait cycles each accumulate in a counter
// - hits counted; write hits too in write-back mode
// - read misses and dirty line write-outs each have a counter
module cache_top #(
	parameter int LINE_BYTES_REQ = 16,
	parameter int CAPACITY_REQ = 1024,
	parameter bit ARBITRATED = 1'b1,
	parameter int COUNT_W = 32,
	// clamp to a power of two in range
	localparam int LINE_BYTES = (LINE_BYTES_REQ < cache_pkg::LINE_BYTES_MIN) ?
		cache_pkg::LINE_BYTES_MIN : (LINE_BYTES_REQ > cache_pkg::LINE_BYTES_MAX) ?
		cache_pkg::LINE_BYTES_MAX : (1 << $clog2(LINE_BYTES_REQ)),
	localparam int CAPACITY = 1 << $clog2((CAPACITY_REQ < LINE_BYTES) ? LINE_BYTES : CAPACITY_REQ),
	localparam int LINE_W = LINE_BYTES * 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic up_valid_in,
	input wire cache_pkg::up_req_t up_req_in,
	output cache_pkg::status_t up_status_out,
	output logic [cache_pkg::DATA_W-1:0] up_rdata_out,
	output cache_pkg::mem_cmd_t mem_cmd_out,
	output logic [LINE_W-1:0] mem_wdata_out,
	input wire logic mem_grant_in,
	input wire cache_pkg::status_t mem_status_in,
	input wire logic [LINE_W-1:0] mem_rdata_in,
	input wire logic [cache_pkg::AV_ADDR_W-1:0] av_address_in,
	input wire logic av_read_in,
	input wire logic av_write_in,
	input wire logic [31:0] av_writedata_in,
	input wire logic [3:0] av_byteenable_in,
	output logic [31:0] av_readdata_out,
	output logic av_waitrequest_out
);
	localparam int NUM_LINES = CAPACITY / LINE_BYTES;
	localparam int OFF = $clog2(LINE_BYTES);
	localparam int IDX_W = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1;
	localparam int LA_W = cache_pkg::ADDR_W - OFF;

	typedef enum {st_idle, st_lookup, st_mem, st_apply, st_next, st_finish} state_t;
	typedef enum {op_evict, op_fetch, op_store} op_t;

	state_t state;
	op_t op;
	cache_pkg::cfg_t cfg;
	cache_pkg::up_req_t cur;
	logic [31:0] region_base;
	logic [31:0] region_size;
	logic [5:0] valid_width;
	logic [31:0] nc_base [cache_pkg::NC_WINDOWS];
	logic [31:0] nc_size [cache_pkg::NC_WINDOWS];
	logic [cache_pkg::NC_WINDOWS-1:0] nc_hit;
	logic [3:0] nbytes;
	logic part;
	logic last_part;
	logic uncached;
	logic refilled;
	logic [LA_W-1:0] lin;
	logic [LINE_W-1:0] linebuf;
	logic [63:0] racc;
	// per-line data, tag, valid and dirty
	logic [LINE_W-1:0] line_mem [1 << IDX_W];
	logic [LA_W-1:0] tag_mem [1 << IDX_W];
	logic [(1 << IDX_W)-1:0] valid_mem;
	logic [(1 << IDX_W)-1:0] dirty_mem;
	logic [IDX_W-1:0] idx;
	logic hit;
	logic [LA_W-1:0] victim_line;
	logic [LINE_W-1:0] src_line;
	logic [LINE_W-1:0] merged;
	logic [63:0] rbytes;
	logic [31:0] addr_mask;
	logic [31:0] a_in;
	logic [31:0] a_end;
	logic [3:0] nb_in;
	logic size_ok;
	logic in_region;
	logic unc_now;
	logic misal_in;
	logic cross_in;
	logic accept;
	logic mem_busy;
	logic mem_done;
	logic fill_now;
	logic hit_wr_now;
	logic [COUNT_W-1:0] cnt [cache_pkg::NUM_COUNTERS];
	logic [cache_pkg::NUM_COUNTERS-1:0] cnt_inc;
	logic [COUNT_W-1:0] hits_now;
	logic av_wr_now;
	logic [1:0] nc_sel;
	logic [3:0] cnt_sel;
	logic [31:0] rd_value;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// incoming request decode: mask, size, region, alignment
	always_comb begin
		addr_mask = (valid_width >= cache_pkg::VALID_WIDTH_FULL) ? 32'hFFFF_FFFF :
			((32'h0000_0001 << valid_width) - 32'h0000_0001);
		a_in = up_req_in.addr & addr_mask;
		case (up_req_in.size)
			cache_pkg::SIZE_BYTE: nb_in = 4'h1;
			cache_pkg::SIZE_HALF: nb_in = 4'h2;
			cache_pkg::SIZE_WORD: nb_in = 4'h4;
			cache_pkg::SIZE_DWORD: nb_in = 4'h8;
			default: nb_in = 4'h0;
		endcase
		size_ok = (nb_in != 4'h0);
		a_end = a_in + 32'(nb_in) - 32'h0000_0001;
		in_region = (region_size == '0) || ((a_in - region_base) < region_size);
		// caching off makes every access uncached
		unc_now = !cfg.caching_on || (|nc_hit);
		misal_in = (a_in[2:0] & (nb_in[2:0] - 3'h1)) != 3'h0;
		cross_in = a_in[31:OFF] != a_end[31:OFF];
		accept = (state == st_idle) && up_valid_in && size_ok && in_region;
	end

	for (genvar w = 0; w < cache_pkg::NC_WINDOWS; w++) begin : g_nc
		assign nc_hit[w] = (nc_size[w] != '0) && ((a_in - nc_base[w]) < nc_size[w]);
	end

	always_comb begin
		idx = lin[IDX_W-1:0];
		hit = valid_mem[idx] && (tag_mem[idx] == lin);
		victim_line = tag_mem[idx];
		src_line = uncached ? linebuf : line_mem[idx];
		mem_busy = mem_cmd_out.rd || mem_cmd_out.wr;
		mem_done = mem_busy && (mem_status_in != cache_pkg::wait_status);
		fill_now = (state == st_mem) && (op == op_fetch) && mem_done && !uncached &&
			(mem_status_in == cache_pkg::ok_status);
		hit_wr_now = (state == st_lookup) && !uncached && hit && cur.write;
	end

	// byte merge and extract for the bytes of the access inside this line
	always_comb begin
		logic [31:0] abs_addr;
		logic [3:0] lane;
		abs_addr = '0;
		lane = '0;
		merged = src_line;
		rbytes = '0;
		for (int k = 0; k < cache_pkg::MAX_ACCESS_BYTES; k++) begin
			abs_addr = cur.addr + 32'(k);
			// lane order follows byte order flag
			lane = cfg.big_endian ? (nbytes - 4'h1 - 4'(k)) : 4'(k);
			// bytes of a two-line access split by line
			if ((4'(k) < nbytes) && (abs_addr[31:OFF] == lin)) begin
				merged[{abs_addr[OFF-1:0], 3'b000} +: 8] = cur.wdata[{lane[2:0], 3'b000} +: 8];
				rbytes[{lane[2:0], 3'b000} +: 8] = src_line[{abs_addr[OFF-1:0], 3'b000} +: 8];
			end
		end
	end

	// request sequencer and downstream port
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= st_idle;
			op <= op_fetch;
			cur <= '0;
			nbytes <= '0;
			part <= 1'b0;
			last_part <= 1'b0;
			uncached <= 1'b0;
			refilled <= 1'b0;
			lin <= '0;
			linebuf <= '0;
			racc <= '0;
			up_status_out <= cache_pkg::wait_status;
			up_rdata_out <= '0;
			mem_cmd_out <= '0;
			mem_wdata_out <= '0;
		end else begin
			case (state)
				st_idle: begin
					up_status_out <= cache_pkg::wait_status;
					if (up_valid_in) begin
						cur <= up_req_in;
						cur.addr <= a_in;
						nbytes <= nb_in;
						lin <= a_in[31:OFF];
						part <= 1'b0;
						last_part <= cross_in;
						// cacheability fixed by the first line
						uncached <= unc_now;
						refilled <= 1'b0;
						racc <= '0;
						// bad size or outside region ends in error
						if (!size_ok || !in_region) begin
							up_status_out <= cache_pkg::error_status;
							state <= st_finish;
						end else begin
							state <= st_lookup;
						end
					end
				end
				st_lookup: begin
					mem_cmd_out.addr <= {lin, {OFF{1'b0}}};
					if (uncached) begin
						op <= op_fetch;
						state <= st_mem;
					end else if (hit) begin
						racc <= racc | rbytes;
						// write-through hit stores the line at once
						if (cur.write && !cfg.copyback_policy) begin
							linebuf <= merged;
							op <= op_store;
							state <= st_mem;
						end else begin
							state <= st_next;
						end
					end else if (valid_mem[idx] && dirty_mem[idx]) begin
						// dirty victim goes out before the fetch
						linebuf <= src_line;
						op <= op_evict;
						mem_cmd_out.addr <= {victim_line, {OFF{1'b0}}};
						state <= st_mem;
					end else begin
						op <= op_fetch;
						state <= st_mem;
					end
				end
				st_mem: begin
					if (!mem_busy) begin
						mem_cmd_out.req <= ARBITRATED;
						if (!ARBITRATED || (mem_cmd_out.req && mem_grant_in)) begin
							mem_cmd_out.rd <= (op == op_fetch);
							mem_cmd_out.wr <= (op != op_fetch);
							mem_wdata_out <= linebuf;
						end
					end else if (mem_done) begin
						mem_cmd_out.req <= 1'b0;
						mem_cmd_out.rd <= 1'b0;
						mem_cmd_out.wr <= 1'b0;
						if (mem_status_in != cache_pkg::ok_status) begin
							up_status_out <= cache_pkg::error_status;
							state <= st_finish;
						end else if (op == op_evict) begin
							op <= op_fetch;
							mem_cmd_out.addr <= {lin, {OFF{1'b0}}};
						end else if (op == op_fetch && uncached) begin
							linebuf <= mem_rdata_in;
							state <= st_apply;
						end else if (op == op_fetch) begin
							refilled <= 1'b1;
							state <= st_lookup;
						end else begin
							state <= st_next;
						end
					end
				end
				st_apply: begin
					racc <= racc | rbytes;
					if (cur.write) begin
						linebuf <= merged;
						op <= op_store;
						state <= st_mem;
					end else begin
						state <= st_next;
					end
				end
				st_next: begin
					if (last_part && !part) begin
						part <= 1'b1;
						lin <= lin + 1'b1;
						refilled <= 1'b0;
						state <= st_lookup;
					end else begin
						up_status_out <= cache_pkg::ok_status;
						up_rdata_out <= racc;
						state <= st_finish;
					end
				end
				st_finish: begin
					up_status_out <= cache_pkg::wait_status;
					state <= st_idle;
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// line data and tags; refill or hit write keeps line resident
	always_ff @(posedge clk_in) begin
		if (fill_now) begin
			line_mem[idx] <= mem_rdata_in;
			tag_mem[idx] <= lin;
		end else if (hit_wr_now) begin
			line_mem[idx] <= merged;
		end
	end

	// valid and dirty state per line
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			valid_mem <= '0;
			dirty_mem <= '0;
		end else if (fill_now) begin
			valid_mem[idx] <= 1'b1;
			dirty_mem[idx] <= 1'b0;
		end else if (hit_wr_now) begin
			// only write-back leaves a line dirty
			dirty_mem[idx] <= dirty_mem[idx] | cfg.copyback_policy;
		end
	end

	// profiling events
	always_comb begin
		cnt_inc = '0;
		cnt_inc[cache_pkg::CNT_RD_CACHED] = accept && !up_req_in.write && !unc_now;
		cnt_inc[cache_pkg::CNT_WR_CACHED] = accept && up_req_in.write && !unc_now;
		cnt_inc[cache_pkg::CNT_RD_UNCACHED] = accept && !up_req_in.write && unc_now;
		cnt_inc[cache_pkg::CNT_WR_UNCACHED] = accept && up_req_in.write && unc_now;
		cnt_inc[cache_pkg::CNT_MISALIGNED] = accept && misal_in;
		cnt_inc[cache_pkg::CNT_CROSS_LINE] = accept && cross_in;
		cnt_inc[cache_pkg::CNT_RD_WAITS] = mem_cmd_out.rd && (mem_status_in == cache_pkg::wait_status);
		cnt_inc[cache_pkg::CNT_WR_WAITS] = mem_cmd_out.wr && (mem_status_in == cache_pkg::wait_status);
		// hits, write hits only in write-back
		cnt_inc[cache_pkg::CNT_HITS] = (state == st_lookup) && !uncached && hit && !refilled &&
			(!cur.write || cfg.copyback_policy);
		cnt_inc[cache_pkg::CNT_RD_MISSES] = (state == st_lookup) && !uncached && !hit && !cur.write;
		cnt_inc[cache_pkg::CNT_DIRTY_WRITES] = (state == st_lookup) && !uncached && !hit &&
			valid_mem[idx] && dirty_mem[idx];
	end

	// one counter per event, gated by profiling
	for (genvar c = 0; c < cache_pkg::NUM_COUNTERS; c++) begin : g_cnt
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				cnt[c] <= '0;
			end else if (cfg.profiling_on && cnt_inc[c]) begin
				cnt[c] <= cnt[c] + 1'b1;
			end
		end
	end
	assign hits_now = cnt[cache_pkg::CNT_HITS];

	// avalon register read decode
	always_comb begin
		av_wr_now = av_write_in && !av_waitrequest_out;
		nc_sel = 2'((av_address_in - cache_pkg::REG_NC_FIRST) >> cache_pkg::NC_STRIDE_SHIFT);
		cnt_sel = 4'((av_address_in - cache_pkg::REG_COUNT_FIRST) >> cache_pkg::WORD_SHIFT);
		rd_value = '0;
		if (av_address_in == cache_pkg::REG_CTRL) begin
			rd_value = 32'(cfg);
		end else if (av_address_in == cache_pkg::REG_REGION_BASE) begin
			rd_value = region_base;
		end else if (av_address_in == cache_pkg::REG_REGION_SIZE) begin
			rd_value = region_size;
		end else if (av_address_in == cache_pkg::REG_VALID_WIDTH) begin
			rd_value = 32'(valid_width);
		end else if (av_address_in[1:0] == 2'h0 && av_address_in >= cache_pkg::REG_NC_FIRST &&
			av_address_in <= cache_pkg::REG_NC_LAST) begin
			rd_value = av_address_in[cache_pkg::NC_SIZE_BIT] ? nc_size[nc_sel] : nc_base[nc_sel];
		end else if (av_address_in[1:0] == 2'h0 && av_address_in >= cache_pkg::REG_COUNT_FIRST &&
			av_address_in <= cache_pkg::REG_COUNT_LAST) begin
			rd_value = 32'(cnt[cnt_sel]);
		end
	end

	// avalon handshake: one wait cycle, then the answer
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			av_waitrequest_out <= 1'b1;
			av_readdata_out <= '0;
		end else if ((av_read_in || av_write_in) && av_waitrequest_out) begin
			av_waitrequest_out <= 1'b0;
			av_readdata_out <= rd_value;
		end else begin
			av_waitrequest_out <= 1'b1;
		end
	end

	// configuration registers written by software
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg <= cache_pkg::CFG_RESET;
			region_base <= cache_pkg::REGION_BASE_RESET;
			region_size <= cache_pkg::REGION_SIZE_RESET;
			valid_width <= cache_pkg::VALID_WIDTH_RESET;
			for (int w = 0; w < cache_pkg::NC_WINDOWS; w++) begin
				nc_base[w] <= cache_pkg::NC_RESET;
				nc_size[w] <= cache_pkg::NC_RESET;
			end
		end else if (av_wr_now) begin
			if (av_address_in == cache_pkg::REG_CTRL && av_byteenable_in[0]) begin
				cfg <= av_writedata_in[3:0];
			end
			if (av_address_in == cache_pkg::REG_REGION_BASE) begin
				region_base <= be_merge(region_base, av_writedata_in, av_byteenable_in);
			end
			if (av_address_in == cache_pkg::REG_REGION_SIZE) begin
				region_size <= be_merge(region_size, av_writedata_in, av_byteenable_in);
			end
			if (av_address_in == cache_pkg::REG_VALID_WIDTH && av_byteenable_in[0]) begin
				valid_width <= av_writedata_in[5:0];
			end
			for (int w = 0; w < cache_pkg::NC_WINDOWS; w++) begin
				if (av_address_in[1:0] == 2'h0 && av_address_in >= cache_pkg::REG_NC_FIRST &&
					av_address_in <= cache_pkg::REG_NC_LAST && nc_sel == 2'(w)) begin
					if (av_address_in[cache_pkg::NC_SIZE_BIT]) begin
						nc_size[w] <= be_merge(nc_size[w], av_writedata_in, av_byteenable_in);
					end else begin
						nc_base[w] <= be_merge(nc_base[w], av_writedata_in, av_byteenable_in);
					end
				end
			end
		end
	end

	// checks on geometry, sequencing and counters
	AST_LINE_SIZE: assert property (@(posedge clk_in) disable iff (rst_in)
		LINE_BYTES >= cache_pkg::LINE_BYTES_MIN && LINE_BYTES <= cache_pkg::LINE_BYTES_MAX &&
		(LINE_BYTES & (LINE_BYTES - 1)) == 0) else $error("line size out of range");
	AST_CAPACITY_POW2: assert property (@(posedge clk_in) disable iff (rst_in)
		CAPACITY >= CAPACITY_REQ && (CAPACITY & (CAPACITY - 1)) == 0 &&
		CAPACITY % LINE_BYTES == 0) else $error("capacity not a rounded power of two");
	AST_WHOLE_LINE: assert property (@(posedge clk_in) disable iff (rst_in)
		mem_busy && mem_status_in == cache_pkg::wait_status |=> mem_busy &&
		mem_cmd_out.addr[OFF-1:0] == '0 && $stable(mem_cmd_out.addr) && $stable(mem_wdata_out))
		else $error("line transfer not aligned or not held");
	AST_WT_STORE: assert property (@(posedge clk_in) disable iff (rst_in)
		hit_wr_now && !cfg.copyback_policy |=> state == st_mem && op == op_store &&
		linebuf == $past(merged)) else $error("write-through hit did not store merged line");
	AST_DISABLED_BYPASS: assert property (@(posedge clk_in) disable iff (rst_in)
		accept && !cfg.caching_on |=> uncached && state == st_lookup)
		else $error("access with caching off not uncached");
	AST_STATUS_END: assert property (@(posedge clk_in) disable iff (rst_in)
		up_status_out != cache_pkg::wait_status |=> up_status_out == cache_pkg::wait_status &&
		state == st_idle) else $error("final status longer than one cycle");
	AST_GRANT_FIRST: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(mem_busy) |-> !ARBITRATED || $past(mem_cmd_out.req && mem_grant_in))
		else $error("transfer issued without grant");
	AST_ADDR_MASKED: assert property (@(posedge clk_in) disable iff (rst_in)
		accept |=> (cur.addr & ~$past(addr_mask)) == '0) else $error("address bits not masked");
	AST_PROFILE_FROZEN: assert property (@(posedge clk_in) disable iff (rst_in)
		!cfg.profiling_on |=> hits_now == $past(hits_now)) else $error("counter moved while off");
	AST_EVICT_FIRST: assert property (@(posedge clk_in) disable iff (rst_in)
		cnt_inc[cache_pkg::CNT_DIRTY_WRITES] |=> op == op_evict &&
		mem_cmd_out.addr[31:OFF] == $past(victim_line)) else $error("dirty victim not written first");
endmodule
